/* hw/sls_strap_led.sv */
// Overview of operation
// - Strap pins float during reset, drive afterwards
// - Collision pin strap selects reduced MII
// - Carrier pin strap selects back-to-back mode when the collision strap is also high
// - Interrupt pin polarity from control bit 9
// - Interrupt pin strap gives address bit 0
// - Link indicator low when link is up
// - Speed strap loads speed bit; low=100
// - Duplex strap loads duplex bit; low=full
// - Activity strap loads autoneg; pin toggles
// - Power-down input low enters power-down
// - Unstrapped station address comes up 00001
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module sls_strap_led #(
   parameter int ACT_HALF = sls_pkg::ACT_TOGGLE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic activity,
   input wire logic mii_col,
   input wire logic mii_crs,
   input wire logic core_int,
   input wire logic col_i,
   output logic col_o,
   output logic col_oe,
   input wire logic crs_i,
   output logic crs_o,
   output logic crs_oe,
   input wire logic int_i,
   output logic int_o,
   output logic int_oe,
   output logic link_indicator,
   output logic link_oe,
   input wire logic speed_i,
   output logic speed_indicator,
   output logic speed_oe,
   input wire logic duplex_i,
   output logic duplex_indicator,
   output logic duplex_oe,
   input wire logic activity_i,
   output logic activity_indicator,
   output logic activity_oe,
   input wire logic [2:0] addr_hi_i,
   input wire logic power_down_n,
   output logic strap_pull_en,
   output logic power_down,
   output logic reduced_mii,
   output logic reduced_mii_back_to_back,
   output logic [4:0] station_address,
   output logic speed_select,
   output logic duplex_select,
   output logic autoneg_enable_bit,
   output logic irq
);
   typedef struct packed {
      sls_pkg::sls_state_t st;
      logic [1:0] wait_cnt;
      logic rmii;
      logic btb;
      logic [4:0] addr;
      logic spd;
      logic dup;
      logic aneg;
      logic int_pol;
      logic [sls_pkg::EV_W-1:0] stat;
      logic [sls_pkg::EV_W-1:0] mask;
      logic link_q;
      logic pd;
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic col;
      logic crs;
      logic intp;
      logic link;
      logic spdp;
      logic dupp;
      logic oe;
      logic irq;
   } sls_top_t;

   sls_top_t r;
   sls_top_t next_r;
   logic int_active;
   logic [sls_pkg::EV_W-1:0] ev_set;
   logic [sls_pkg::EV_W-1:0] ev_clr;
   logic wr_done;
   logic act_led;

   sls_sync_if #(.W(sls_pkg::SYNC_W)) pins ();

   // Straps cross here; power-down enters as a request so reset zeros mean none
   sls_sync #(.W(sls_pkg::SYNC_W)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d({!power_down_n, addr_hi_i, activity_i, duplex_i, speed_i, int_i, crs_i, col_i}),
      .out(pins)
   );

   sls_act_blink #(.HALF(ACT_HALF)) u_blink (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .run(r.st == sls_pkg::SLS_RUN),
      .activity(activity),
      .led_n(act_led)
   );

   // Address decode for the error flag; the read path decodes in sls_read
   function automatic logic sls_mapped(input logic [7:0] a);
      sls_mapped = (a == sls_pkg::REG_CTRL0) || (a == sls_pkg::REG_CTRL1F) ||
         (a == sls_pkg::REG_STRAP) || (a == sls_pkg::REG_IRQ_STAT) ||
         (a == sls_pkg::REG_IRQ_MASK) || (a == sls_pkg::REG_LIVE);
   endfunction

   function automatic logic [31:0] sls_read(input sls_top_t s, input logic [7:0] a);
      sls_read = 32'h00000000;
      case (a)
         sls_pkg::REG_CTRL0: begin
            sls_read[sls_pkg::BIT_SPEED] = s.spd;
            sls_read[sls_pkg::BIT_ANEG] = s.aneg;
            sls_read[sls_pkg::BIT_DUPLEX] = s.dup;
         end
         sls_pkg::REG_CTRL1F: sls_read[sls_pkg::BIT_INT_POL] = s.int_pol;
         sls_pkg::REG_STRAP: begin
            sls_read[sls_pkg::BIT_ST_RMII] = s.rmii;
            sls_read[sls_pkg::BIT_ST_BTB] = s.btb;
            sls_read[sls_pkg::BIT_ST_ADDR +: 5] = s.addr;
         end
         sls_pkg::REG_IRQ_STAT: sls_read[sls_pkg::EV_W-1:0] = s.stat;
         sls_pkg::REG_IRQ_MASK: sls_read[sls_pkg::EV_W-1:0] = s.mask;
         sls_pkg::REG_LIVE: sls_read[3:0] = {s.pd, s.st == sls_pkg::SLS_RUN, s.link_q, s.irq};
         default: sls_read = 32'h00000000;
      endcase
   endfunction

   // Interrupt pin carries core or masked local events
   assign int_active = core_int | (|(r.stat & r.mask));
   assign wr_done = psel && penable && r.rdy && pwrite && !r.err;

   // Hardware events; a set in the clearing cycle survives
   always_comb begin
      ev_set = '0;
      ev_set[sls_pkg::EV_LINK] = (r.st == sls_pkg::SLS_RUN) && (link_up != r.link_q);
      ev_set[sls_pkg::EV_PDOWN] = pins.q[sls_pkg::PIN_PDN] && !r.pd;
      ev_set[sls_pkg::EV_STRAP] = (r.st == sls_pkg::SLS_CAPTURE);
      ev_clr = '0;
      if (wr_done && paddr == sls_pkg::REG_IRQ_STAT) begin
         ev_clr = pwdata[sls_pkg::EV_W-1:0];
      end
   end

   // Strap sequencer, register file and pin drivers
   always_comb begin
      next_r = r;
      if (ce) begin
         case (r.st)
            sls_pkg::SLS_SETTLE: begin
               // Synchroniser holds reset zeros until it has refilled
               if (r.wait_cnt == sls_pkg::STRAP_SETTLE) begin
                  next_r.st = sls_pkg::SLS_CAPTURE;
               end else begin
                  next_r.wait_cnt = r.wait_cnt + 2'h1;
               end
            end
            sls_pkg::SLS_CAPTURE: begin
               next_r.rmii = pins.q[sls_pkg::PIN_COL];
               next_r.btb = pins.q[sls_pkg::PIN_CRS] & pins.q[sls_pkg::PIN_COL];
               next_r.addr = {pins.q[sls_pkg::PIN_ADDR_LO +: sls_pkg::ADDR_HI_W], 1'b0,
                  pins.q[sls_pkg::PIN_INT]};
               next_r.spd = pins.q[sls_pkg::PIN_SPD];
               next_r.dup = pins.q[sls_pkg::PIN_DUP];
               next_r.aneg = pins.q[sls_pkg::PIN_ACT];
               next_r.st = sls_pkg::SLS_RUN;
            end
            sls_pkg::SLS_RUN: next_r.st = sls_pkg::SLS_RUN;
            default: next_r.st = sls_pkg::SLS_SETTLE;
         endcase

         next_r.link_q = link_up;
         next_r.pd = pins.q[sls_pkg::PIN_PDN];
         next_r.stat = (r.stat & ~ev_clr) | ev_set;

         // APB: one wait state, write lands on the pready edge
         next_r.rdy = 1'b0;
         next_r.err = 1'b0;
         if (psel && penable && !r.rdy) begin
            next_r.rdy = 1'b1;
            next_r.err = !sls_mapped(paddr);
            next_r.rdata = pwrite ? 32'h00000000 : sls_read(r, paddr);
         end
         if (wr_done) begin
            case (paddr)
               sls_pkg::REG_CTRL0: begin
                  next_r.spd = pwdata[sls_pkg::BIT_SPEED];
                  next_r.aneg = pwdata[sls_pkg::BIT_ANEG];
                  next_r.dup = pwdata[sls_pkg::BIT_DUPLEX];
               end
               sls_pkg::REG_CTRL1F: next_r.int_pol = pwdata[sls_pkg::BIT_INT_POL];
               sls_pkg::REG_IRQ_MASK: next_r.mask = pwdata[sls_pkg::EV_W-1:0];
               default: next_r.int_pol = r.int_pol;
            endcase
         end

         // Pins released only once straps are safely held
         next_r.oe = (next_r.st == sls_pkg::SLS_RUN);
         next_r.col = mii_col;
         next_r.crs = mii_crs;
         next_r.intp = r.int_pol ? int_active : !int_active;
         next_r.link = !link_up;
         next_r.spdp = !speed_100;
         next_r.dupp = !full_duplex;
         next_r.irq = |(next_r.stat & r.mask);
      end
   end

   // Reset leaves address 00001 as the pulls would give
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.addr <= sls_pkg::STATION_ADDR_RST;
         r.mask <= sls_pkg::IRQ_MASK_RST;
         r.intp <= 1'b1;
         r.link <= 1'b1;
         r.spdp <= 1'b1;
         r.dupp <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.rdata;
   assign pready = r.rdy;
   assign pslverr = r.err;
   assign col_o = r.col;
   assign col_oe = r.oe;
   assign crs_o = r.crs;
   assign crs_oe = r.oe;
   assign int_o = r.intp;
   assign int_oe = r.oe;
   assign link_indicator = r.link;
   assign link_oe = r.oe;
   assign speed_indicator = r.spdp;
   assign speed_oe = r.oe;
   assign duplex_indicator = r.dupp;
   assign duplex_oe = r.oe;
   assign activity_indicator = act_led;
   assign activity_oe = r.oe;
   assign strap_pull_en = !r.oe;
   assign power_down = r.pd;
   assign reduced_mii = r.rmii;
   assign reduced_mii_back_to_back = r.btb;
   assign station_address = r.addr;
   assign speed_select = r.spd;
   assign duplex_select = r.dup;
   assign autoneg_enable_bit = r.aneg;
   assign irq = r.irq;

   property p_pins_float;
      @(posedge pclk) disable iff (!presetn)
      (r.st != sls_pkg::SLS_RUN) |-> (!col_oe && !int_oe && !speed_oe && strap_pull_en);
   endproperty
   a_pins_float: assert property (p_pins_float) else $error("strap pin driven before run");

   property p_rmii_capture;
      @(posedge pclk) disable iff (!presetn)
      (ce && r.st == sls_pkg::SLS_CAPTURE) |=> (reduced_mii == $past(pins.q[sls_pkg::PIN_COL])) && col_oe;
   endproperty
   a_rmii_capture: assert property (p_rmii_capture) else $error("reduced mii strap not taken");

   property p_btb_gate;
      @(posedge pclk) disable iff (!presetn)
      reduced_mii_back_to_back |-> reduced_mii;
   endproperty
   a_btb_gate: assert property (p_btb_gate) else $error("back-to-back without reduced mii");

   property p_int_pol;
      @(posedge pclk) disable iff (!presetn)
      (ce && r.st == sls_pkg::SLS_RUN) |=> (int_o == ($past(r.int_pol) ~^ $past(int_active)));
   endproperty
   a_int_pol: assert property (p_int_pol) else $error("interrupt pin polarity wrong");

   property p_addr0;
      @(posedge pclk) disable iff (!presetn)
      (ce && r.st == sls_pkg::SLS_CAPTURE) |=> (station_address[0] == $past(pins.q[sls_pkg::PIN_INT]));
   endproperty
   a_addr0: assert property (p_addr0) else $error("address bit 0 not latched");

   property p_link;
      @(posedge pclk) disable iff (!presetn)
      (ce && link_up) ##1 (ce && link_up) |=> !link_indicator;
   endproperty
   a_link: assert property (p_link) else $error("link indicator not low with link");

   property p_speed;
      @(posedge pclk) disable iff (!presetn)
      ce |=> (speed_indicator == !$past(speed_100)) && (duplex_indicator == !$past(full_duplex));
   endproperty
   a_speed: assert property (p_speed) else $error("speed or duplex indicator wrong");

   property p_dup_strap;
      @(posedge pclk) disable iff (!presetn)
      (ce && r.st == sls_pkg::SLS_CAPTURE) |=> (duplex_select == $past(pins.q[sls_pkg::PIN_DUP]))
         && (speed_select == $past(pins.q[sls_pkg::PIN_SPD]));
   endproperty
   a_dup_strap: assert property (p_dup_strap) else $error("duplex or speed strap not loaded");

   property p_power_down;
      @(posedge pclk) disable iff (!presetn)
      ce |=> (power_down == $past(pins.q[sls_pkg::PIN_PDN]));
   endproperty
   a_power_down: assert property (p_power_down) else $error("power-down does not follow input");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (r.st == sls_pkg::SLS_RUN) |=> $stable(reduced_mii) && $stable(station_address) && $stable(r.st);
   endproperty
   a_hold: assert property (p_hold) else $error("strap value changed after capture");

   property p_addr_reset;
      @(posedge pclk) disable iff (!presetn)
      (r.st == sls_pkg::SLS_SETTLE) |-> (station_address == sls_pkg::STATION_ADDR_RST);
   endproperty
   a_addr_reset: assert property (p_addr_reset) else $error("station address default wrong");
endmodule

/* hw/sls_pkg.sv */
package sls_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int ACT_TOGGLE_NS = 16000;
   localparam int ACT_TOGGLE_CYCLES = ACT_TOGGLE_NS / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // Synchronised pin vector layout
   localparam int SYNC_W = 10;
   localparam int PIN_COL = 0;
   localparam int PIN_CRS = 1;
   localparam int PIN_INT = 2;
   localparam int PIN_SPD = 3;
   localparam int PIN_DUP = 4;
   localparam int PIN_ACT = 5;
   localparam int PIN_ADDR_LO = 6;
   localparam int PIN_PDN = 9;
   localparam int ADDR_HI_W = 3;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL0 = 8'h00;
   localparam logic [7:0] REG_CTRL1F = 8'h04;
   localparam logic [7:0] REG_STRAP = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam logic [7:0] REG_LIVE = 8'h14;

   // Field positions
   localparam int BIT_DUPLEX = 8;
   localparam int BIT_ANEG = 12;
   localparam int BIT_SPEED = 13;
   localparam int BIT_INT_POL = 9;
   localparam int BIT_ST_RMII = 0;
   localparam int BIT_ST_BTB = 1;
   localparam int BIT_ST_ADDR = 2;
   localparam int EV_LINK = 0;
   localparam int EV_PDOWN = 1;
   localparam int EV_STRAP = 2;
   localparam int EV_W = 3;

   // Reset values
   localparam logic [4:0] STATION_ADDR_RST = 5'h01;
   localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;

   typedef enum logic [1:0] {
      SLS_SETTLE = 2'b00,
      SLS_CAPTURE = 2'b01,
      SLS_RUN = 2'b10
   } sls_state_t;
endpackage

/* hw/sls_sync_if.sv */
`timescale 1ns/1ps
interface sls_sync_if #(parameter int W = 1);
   logic [W-1:0] q;
   modport src (output q);
   modport dst (input q);
endinterface

/* hw/sls_sync.sv */
`timescale 1ns/1ps
module sls_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   sls_sync_if.src out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sls_sync_st_t;

   sls_sync_st_t r;
   sls_sync_st_t next_r;

   // First stage feeds only the second one
   always_comb begin
      next_r = r;
      if (ce) begin
         next_r.s1 = d;
         next_r.s2 = r.s1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign out.q = r.s2;
endmodule

/* hw/sls_act_blink.sv */
`timescale 1ns/1ps
module sls_act_blink #(
   parameter int HALF = sls_pkg::ACT_TOGGLE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic run,
   input wire logic activity,
   output logic led_n
);
   typedef struct packed {
      logic [15:0] cnt;
      logic seen;
      logic led;
   } sls_blink_t;

   localparam logic [15:0] LAST = 16'(HALF - 1);

   sls_blink_t r;
   sls_blink_t next_r;

   // Toggle once per period while traffic was seen, else stay dark
   always_comb begin
      next_r = r;
      if (ce) begin
         if (!run) begin
            next_r = '0;
            next_r.led = 1'b1;
         end else if (r.cnt == LAST) begin
            next_r.cnt = '0;
            next_r.seen = activity;
            next_r.led = r.seen ? ~r.led : 1'b1;
         end else begin
            next_r.cnt = r.cnt + 16'h0001;
            next_r.seen = r.seen | activity;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{cnt: 16'h0000, seen: 1'b0, led: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign led_n = r.led;

   property p_blink_dark;
      @(posedge pclk) disable iff (!presetn)
      (ce && !run) |=> led_n;
   endproperty
   a_blink_dark: assert property (p_blink_dark) else $error("activity led lit while not running");

   property p_blink_toggle;
      @(posedge pclk) disable iff (!presetn)
      (ce && run && r.cnt == LAST && r.seen) |=> (led_n != $past(led_n));
   endproperty
   a_blink_toggle: assert property (p_blink_toggle) else $error("activity led did not toggle");
endmodule

/* test/sls_board_model.sv */
`timescale 1ns/1ps
// Board straps on the six shared pins; LEDs are plain loads
module sls_board_model (
   input wire logic [8:0] strap,
   input wire logic [5:0] pin_o,
   input wire logic [5:0] pin_oe,
   output logic [5:0] pin_i,
   output logic [2:0] addr_hi_i
);
   // Resistor level shows only while the device leaves the pin undriven
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         pin_i[k] = pin_oe[k] ? pin_o[k] : strap[8 - k];
      end
      addr_hi_i = strap[2:0];
   end
endmodule

/* test/sls_strap_led_tb_top.sv */
`timescale 1ns/1ps
module sls_strap_led_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, link_indicator, link_oe, strap_pull_en, power_down, irq;
   logic reduced_mii, reduced_mii_back_to_back, speed_select, duplex_select, autoneg_enable_bit;
   logic [4:0] station_address, sa;
   logic link_up = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0, activity = 1'b0;
   logic mii_col = 1'b0, mii_crs = 1'b0, core_int = 1'b0, power_down_n = 1'b1, prev, ce = 1'b1;
   logic [8:0] strap = 9'h078;
   wire [5:0] pin_o, pin_oe;
   logic [5:0] pin_i;
   logic [4:0] v;
   logic [2:0] addr_hi_i;
   logic [31:0] ctrl, stv;
   logic [8:0] tbl [3] = '{9'h078, 9'h185, 9'h0EA};
   int err_total = 0, checks_done = 0, cnt;

   // Free-running 250 MHz clock
   always #2 pclk = ~pclk;

   sls_strap_led #(.ACT_HALF(8)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link_up(link_up), .speed_100(speed_100),
      .full_duplex(full_duplex), .activity(activity), .mii_col(mii_col), .mii_crs(mii_crs),
      .core_int(core_int), .col_i(pin_i[0]), .col_o(pin_o[0]), .col_oe(pin_oe[0]),
      .crs_i(pin_i[1]), .crs_o(pin_o[1]), .crs_oe(pin_oe[1]), .int_i(pin_i[2]), .int_o(pin_o[2]),
      .int_oe(pin_oe[2]), .link_indicator(link_indicator), .link_oe(link_oe), .speed_i(pin_i[3]),
      .speed_indicator(pin_o[3]), .speed_oe(pin_oe[3]), .duplex_i(pin_i[4]),
      .duplex_indicator(pin_o[4]), .duplex_oe(pin_oe[4]), .activity_i(pin_i[5]),
      .activity_indicator(pin_o[5]), .activity_oe(pin_oe[5]), .addr_hi_i(addr_hi_i),
      .power_down_n(power_down_n), .strap_pull_en(strap_pull_en), .power_down(power_down),
      .reduced_mii(reduced_mii), .reduced_mii_back_to_back(reduced_mii_back_to_back),
      .station_address(station_address), .speed_select(speed_select),
      .duplex_select(duplex_select), .autoneg_enable_bit(autoneg_enable_bit), .irq(irq));

   sls_board_model board (.strap(strap), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
      .addr_hi_i(addr_hi_i));

   // Verdict and end of run, shared with the watchdog
   task automatic final_report();
      $display("Totals: %0d checks, %0d mismatches", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      check({31'h0, got}, {31'h0, exp}, what);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer, entered just after a rising edge; idle edge after release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic xerr);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk1(n < 20, 1'b1, "pready wait");
      if (w == 1'b0) check(prdata, exp, "read data");
      chk1(pslverr, xerr, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Reset with a board strap set; pins must float until capture is done
   task automatic do_reset(input logic [8:0] s);
      int n;
      n = 0;
      strap <= s;
      presetn <= 1'b0;
      cyc(3);
      check({26'h0, pin_oe}, 32'h0, "oe in reset");
      chk1(strap_pull_en, 1'b1, "pulls in reset");
      check({27'h0, station_address}, 32'h1, "address in reset");
      presetn <= 1'b1;
      while (strap_pull_en !== 1'b0 && n < 20) begin
         cyc(1);
         n++;
      end
      check({26'h0, pin_oe}, 32'h3F, "oe after reset");
      chk1(link_oe, 1'b1, "link oe");
   endtask

   // Watchdog sized well above the expected run
   initial begin
      #100000;
      err_total++;
      final_report();
   end

   // Main sequence
   initial begin
      for (int i = 0; i < 3; i++) begin
         do_reset(tbl[i]);
         sa = {tbl[i][2:0], 1'b0, tbl[i][6]};
         ctrl = (32'(tbl[i][5]) << sls_pkg::BIT_SPEED) | (32'(tbl[i][3]) << sls_pkg::BIT_ANEG);
         ctrl = ctrl | (32'(tbl[i][4]) << sls_pkg::BIT_DUPLEX);
         stv = (32'(sa) << sls_pkg::BIT_ST_ADDR) | 32'(tbl[i][8]);
         stv = stv | (32'(tbl[i][8] & tbl[i][7]) << sls_pkg::BIT_ST_BTB);
         check({27'h0, station_address}, {27'h0, sa}, "station address");
         chk1(reduced_mii, tbl[i][8], "reduced mii");
         chk1(reduced_mii_back_to_back, tbl[i][8] & tbl[i][7], "back to back");
         chk1(speed_select, tbl[i][5], "speed strap");
         chk1(duplex_select, tbl[i][4], "duplex strap");
         chk1(autoneg_enable_bit, tbl[i][3], "autoneg strap");
         apb(1'b0, sls_pkg::REG_CTRL0, 32'h0, ctrl, 1'b0);
         apb(1'b0, sls_pkg::REG_STRAP, 32'h0, stv, 1'b0);
         apb(1'b0, sls_pkg::REG_CTRL1F, 32'h0, 32'h0, 1'b0);
         apb(1'b0, sls_pkg::REG_IRQ_STAT, 32'h0, 32'h1 << sls_pkg::EV_STRAP, 1'b0);
         apb(1'b0, sls_pkg::REG_IRQ_MASK, 32'h0, 32'h0, 1'b0);
         strap <= ~tbl[i];
         cyc(4);
         apb(1'b0, sls_pkg::REG_STRAP, 32'h0, stv, 1'b0);
         check({27'h0, station_address}, {27'h0, sa}, "address held");
         $display("Test straps %0d done", i);
      end
      // Indicators and MII status follow the core one cycle later
      for (int k = 0; k < 6; k++) begin
         v = (k == 5) ? 5'h00 : 5'(1 << k);
         {mii_crs, mii_col, full_duplex, speed_100, link_up} <= v;
         cyc(2);
         chk1(link_indicator, ~v[0], "link led");
         chk1(pin_o[3], ~v[1], "speed led");
         chk1(pin_o[4], ~v[2], "duplex led");
         chk1(pin_o[0], v[3], "collision out");
         chk1(pin_o[1], v[4], "carrier out");
      end
      $display("Test indicators done");
      // Clock enable low freezes every flop, indicators included
      ce <= 1'b0;
      link_up <= 1'b1;
      cyc(3);
      chk1(link_indicator, 1'b1, "frozen by ce");
      ce <= 1'b1;
      cyc(2);
      chk1(link_indicator, 1'b0, "runs after ce");
      link_up <= 1'b0;
      cyc(2);
      $display("Test clock enable done");
      // Interrupt pin polarity: default active low, bit 9 selects active high
      core_int <= 1'b1;
      cyc(2);
      chk1(pin_o[2], 1'b0, "int low active");
      apb(1'b1, sls_pkg::REG_CTRL1F, 32'h1 << sls_pkg::BIT_INT_POL, 32'h0, 1'b0);
      cyc(2);
      chk1(pin_o[2], 1'b1, "int high active");
      core_int <= 1'b0;
      cyc(2);
      chk1(pin_o[2], 1'b0, "int idle high pol");
      apb(1'b1, sls_pkg::REG_CTRL1F, 32'h0, 32'h0, 1'b0);
      cyc(2);
      chk1(pin_o[2], 1'b1, "int idle low pol");
      $display("Test interrupt pin done");
      // Sticky status, mask and W1C clear
      apb(1'b1, sls_pkg::REG_IRQ_STAT, 32'h7, 32'h0, 1'b0);
      apb(1'b0, sls_pkg::REG_IRQ_STAT, 32'h0, 32'h0, 1'b0);
      apb(1'b1, sls_pkg::REG_IRQ_MASK, 32'h1, 32'h0, 1'b0);
      chk1(irq, 1'b0, "irq idle");
      link_up <= 1'b1;
      cyc(3);
      chk1(irq, 1'b1, "irq link");
      apb(1'b0, sls_pkg::REG_IRQ_STAT, 32'h0, 32'h1, 1'b0);
      apb(1'b1, sls_pkg::REG_IRQ_STAT, 32'h1, 32'h0, 1'b0);
      chk1(irq, 1'b0, "irq cleared");
      apb(1'b1, sls_pkg::REG_IRQ_MASK, 32'h2, 32'h0, 1'b0);
      link_up <= 1'b0;
      cyc(3);
      chk1(irq, 1'b0, "irq masked");
      apb(1'b1, sls_pkg::REG_IRQ_STAT, 32'h7, 32'h0, 1'b0);
      $display("Test status done");
      // Power-down request from the board, level held low
      power_down_n <= 1'b0;
      cyc(5);
      chk1(power_down, 1'b1, "power down");
      chk1(irq, 1'b1, "irq power down");
      apb(1'b0, sls_pkg::REG_IRQ_STAT, 32'h0, 32'h2, 1'b0);
      apb(1'b0, sls_pkg::REG_LIVE, 32'h0, 32'h0000_000D, 1'b0);
      power_down_n <= 1'b1;
      cyc(5);
      chk1(power_down, 1'b0, "power up");
      $display("Test power down done");
      // Activity blinks while traffic lasts, rests high when idle
      activity <= 1'b1;
      cnt = 0;
      prev = pin_o[5];
      repeat (40) begin
         cyc(1);
         if (pin_o[5] !== prev) cnt++;
         prev = pin_o[5];
      end
      chk1(cnt >= 3, 1'b1, "activity toggles");
      activity <= 1'b0;
      cyc(24);
      chk1(pin_o[5], 1'b1, "activity idle");
      cyc(9);
      chk1(pin_o[5], 1'b1, "activity still idle");
      $display("Test activity done");
      // Register access kinds and an unmapped address
      apb(1'b1, sls_pkg::REG_CTRL0, 32'h0000_2000, 32'h0, 1'b0);
      apb(1'b0, sls_pkg::REG_CTRL0, 32'h0, 32'h0000_2000, 1'b0);
      chk1(speed_select, 1'b1, "speed written");
      chk1(autoneg_enable_bit, 1'b0, "autoneg written");
      apb(1'b1, sls_pkg::REG_STRAP, 32'hFFFF_FFFF, 32'h0, 1'b0);
      apb(1'b0, sls_pkg::REG_STRAP, 32'h0, stv, 1'b0);
      apb(1'b1, 8'h3C, 32'hFFFF_FFFF, 32'h0, 1'b1);
      apb(1'b0, 8'h3C, 32'h0, 32'h0, 1'b1);
      $display("Test registers done");
      final_report();
   end
endmodule
